// ### sac_checker.sv
// Purpose: Stage-two access rights, accessed/dirty flags, nesting and pass-through checks
// Assumes: An external walker supplies the address of each entry to fetch; memory treats
//          a write as an atomic OR of the write data into the 64-bit entry
// Notes:   One request at a time; registers on classic Wishbone
// How it works
// RULE_01: Data read needs read bit everywhere
// RULE_02: Fetch without exec enable needs read only
// RULE_03: Fetch with exec enable needs read and execute
// RULE_04: Write needs write bit in every entry
// RULE_05: Atomic needs read and write everywhere
// RULE_06: Fault on missing translation or denied rights
// RULE_07: Rights may come from cached entries
// RULE_08: Bit 8 accessed, bit 9 dirty
// RULE_09: Atomically set accessed flag on use
// RULE_10: Atomically set dirty flag on leaf write
// RULE_11: Accessed may be set before an abort
// RULE_12: Flags are only ever set, never cleared
// RULE_13: Type 011b sends first-stage accesses through stage two
// RULE_14: No PASID uses the default requester PASID
// RULE_15: Root to PASID-table entries fetched untranslated
// RULE_16: Nested checks at every stage may fault
// RULE_17: Nested untracked structure read needs read
// RULE_18: Nested untracked flag update needs read, write
// RULE_19: Nested tracked structure access needs read, write
// RULE_20: Nested final page follows plain rules
// RULE_21: Pass-through returns address, no rights check
// RULE_22: Pass-through checks host address width
// RULE_23: Entry with no rights or reserved bits faults
// RULE_24: Fault aborts access and reports it
`timescale 1ns/1ps
module sac_checker
    import sac_pkg::*;
#(
    parameter bit TRACK_SUPPORTED = 1'b1
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // Device request
    input  wire logic        req_valid_i,
    output logic             req_ready_o,
    input  wire logic [63:0] req_addr_i,
    input  wire logic [1:0]  req_kind_i,
    input  wire logic        fetch_request_flag_i,
    input  wire logic        req_has_pasid_i,
    input  wire logic [19:0] req_pasid_i,
    // Walk steps from the address generator
    input  wire logic        step_valid_i,
    output logic             step_ready_o,
    input  wire logic [63:0] step_addr_i,
    input  wire logic [1:0]  step_class_i,
    input  wire logic        step_last_i,
    input  wire logic        step_fs_update_i,
    input  wire logic [63:0] step_out_addr_i,
    // Page-walk memory port
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic      [63:0] mem_addr_o,
    output logic      [63:0] mem_wdata_o,
    input  wire logic        mem_ack_i,
    input  wire logic [63:0] mem_rdata_i,
    // Result and fault report
    output logic             done_o,
    output logic             grant_o,
    output logic             fault_o,
    output logic      [2:0]  fault_reason_o,
    output logic      [63:0] out_addr_o,
    output logic      [19:0] out_pasid_o
);

    typedef struct packed {
        sac_state_t  st;
        logic        exec_en;
        logic        track_en;
        logic [2:0]  ttype;
        logic [5:0]  host_address_width;
        logic [19:0] dpasid;
        logic        ack;
        logic        err;
        logic [31:0] rdat;
        logic [63:0] raddr;
        logic [1:0]  kind;
        logic        fetch;
        logic [1:0]  cls;
        logic        last;
        logic        fsupd;
        logic [63:0] saddr;
        logic [63:0] soaddr;
        logic        acc_r;
        logic        acc_w;
        logic        acc_x;
        logic        mreq;
        logic        mwe;
        logic [63:0] maddr;
        logic [63:0] mwdata;
        logic        rready;
        logic        sready;
        logic        done;
        logic        grant;
        logic        fault;
        logic [2:0]  reason;
        logic [63:0] oaddr;
        logic [19:0] opasid;
        logic [15:0] fcnt;
    } sac_regs_t;

    sac_regs_t s_q;
    sac_regs_t s_d;

    // Merge byte lanes of a write into an old value
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // Rights that the pending access needs from every controlling entry
    function automatic logic [2:0] need_rwx(input logic [1:0] cls, input logic [1:0] kind,
                                            input logic fetch, input logic fsupd,
                                            input logic track, input logic xen);
        logic [2:0] n;
        n = 3'h0;
        if (cls == SAC_C_FS) begin
            if (track || fsupd) begin
                n = 3'h3;                           // RULE_18 RULE_19
            end else begin
                n = 3'h1;                           // RULE_17
            end
        end else if (kind == SAC_K_WRITE) begin
            n = 3'h2;                               // RULE_04 RULE_20
        end else if (kind == SAC_K_ATOMIC) begin
            n = 3'h3;                               // RULE_05 RULE_20
        end else if (fetch && xen) begin
            n = 3'h5;                               // RULE_03 RULE_20
        end else begin
            n = 3'h1;                               // RULE_01 RULE_02 RULE_20
        end
        return n;
    endfunction : need_rwx

    logic        accept;
    logic        pt_mode;
    logic        above_haw;
    logic        track_eff;
    logic        checked;
    logic [51:0] rsvd_bits;
    logic        entry_bad;
    logic [63:0] set_mask;
    logic [2:0]  need;
    logic        rights_ok;

    // Helper terms from current state and inputs
    assign accept    = req_valid_i && s_q.rready;
    assign pt_mode   = (s_q.ttype == SAC_TT_PASS);
    assign above_haw = ((req_addr_i >> s_q.host_address_width) != 64'h0);
    assign track_eff = s_q.track_en && TRACK_SUPPORTED;
    // Context-class fetches and first-stage fetches outside nesting skip stage-two checks
    assign checked   = (s_q.cls == SAC_C_FINAL) ||
                       (s_q.cls == SAC_C_FS && s_q.ttype == SAC_TT_NESTED);      // RULE_13 RULE_15
    assign rsvd_bits = mem_rdata_i[SAC_E_TOP:0] >> s_q.host_address_width;
    assign entry_bad = (!mem_rdata_i[SAC_E_R] && !mem_rdata_i[SAC_E_W]) ||
                       (rsvd_bits != 52'h0);                                     // RULE_23
    assign need      = need_rwx(s_q.cls, s_q.kind, s_q.fetch, s_q.fsupd, track_eff, s_q.exec_en);
    assign rights_ok = (!need[0] || s_q.acc_r) && (!need[1] || s_q.acc_w) &&
                       (!need[2] || s_q.acc_x);

    // Flags to OR into the entry just read; memory applies them atomically
    always_comb begin
        set_mask = 64'h0;
        if (track_eff) begin
            set_mask[SAC_E_ACC] = !mem_rdata_i[SAC_E_ACC];                     // RULE_08 RULE_09
            if (s_q.cls == SAC_C_FINAL && s_q.last && s_q.kind != SAC_K_READ) begin
                set_mask[SAC_E_DIRT] = !mem_rdata_i[SAC_E_DIRT];               // RULE_10
            end
        end
    end

    // Next-state logic for bus slave and walk sequencer
    always_comb begin
        s_d      = s_q;
        s_d.ack  = 1'b0;
        s_d.err  = 1'b0;
        s_d.done = 1'b0;
        // Wishbone slave: one answer per request, dropped the cycle after
        if (wb_cyc_i && wb_stb_i && !s_q.ack && !s_q.err) begin
            s_d.ack  = 1'b1;
            s_d.rdat = 32'h0;
            unique case (wb_adr_i)
                SAC_OFS_CTRL: begin
                    s_d.rdat = {27'h0, s_q.ttype, s_q.track_en, s_q.exec_en};
                    if (wb_we_i && wb_sel_i[0]) begin
                        s_d.exec_en  = wb_dat_i[SAC_CTRL_EXEC_BIT];
                        s_d.track_en = wb_dat_i[SAC_CTRL_TRACK_BIT];
                        s_d.ttype    = wb_dat_i[SAC_CTRL_TYPE_LSB +: 3];
                    end
                end
                SAC_OFS_HAW: begin
                    s_d.rdat = {26'h0, s_q.host_address_width};
                    if (wb_we_i && wb_sel_i[0]) begin
                        s_d.host_address_width = wb_dat_i[5:0];
                    end
                end
                SAC_OFS_PASID: begin
                    s_d.rdat = {12'h0, s_q.dpasid};
                    if (wb_we_i) begin
                        s_d.dpasid = 20'(lane_merge({12'h0, s_q.dpasid}, wb_dat_i, wb_sel_i));
                    end
                end
                SAC_OFS_STATUS: begin
                    s_d.rdat = {s_q.fcnt, 7'h0, TRACK_SUPPORTED, 3'h0, s_q.reason, s_q.fault,
                                (s_q.st != SAC_S_IDLE)};
                end
                SAC_OFS_FADDR: begin
                    s_d.rdat = s_q.raddr[31:0];
                end
                default: begin
                    s_d.ack = 1'b0;
                    s_d.err = 1'b1;
                end
            endcase
        end
        // Walk sequencer
        unique case (s_q.st)
            SAC_S_IDLE: begin
                if (accept) begin
                    s_d.rready = 1'b0;
                    s_d.raddr  = req_addr_i;
                    s_d.kind   = req_kind_i;
                    s_d.fetch  = fetch_request_flag_i && (req_kind_i == SAC_K_READ);
                    s_d.opasid = req_has_pasid_i ? req_pasid_i : s_q.dpasid;     // RULE_14
                    s_d.acc_r  = 1'b1;
                    s_d.acc_w  = 1'b1;
                    s_d.acc_x  = 1'b1;
                    s_d.grant  = 1'b0;
                    s_d.fault  = 1'b0;
                    s_d.reason = SAC_F_NONE;
                    s_d.oaddr  = 64'h0;
                    if (pt_mode) begin
                        s_d.st   = SAC_S_FINISH;
                        s_d.done = 1'b1;
                        if (above_haw) begin
                            s_d.fault  = 1'b1;                                 // RULE_22
                            s_d.reason = SAC_F_HAW;
                        end else begin
                            s_d.grant = 1'b1;                                  // RULE_21
                            s_d.oaddr = req_addr_i;
                        end
                    end else if (s_q.ttype == SAC_TT_SECOND || s_q.ttype == SAC_TT_NESTED) begin
                        s_d.st     = SAC_S_STEP;
                        s_d.sready = 1'b1;
                    end else begin
                        s_d.st     = SAC_S_FINISH;
                        s_d.done   = 1'b1;
                        s_d.fault  = 1'b1;
                        s_d.reason = SAC_F_CFG;
                    end
                end
            end
            SAC_S_STEP: begin
                if (step_valid_i && s_q.sready) begin
                    s_d.sready = 1'b0;
                    s_d.saddr  = step_addr_i;
                    s_d.cls    = step_class_i;
                    s_d.last   = step_last_i;
                    s_d.fsupd  = step_fs_update_i;
                    s_d.soaddr = step_out_addr_i;
                    s_d.st     = SAC_S_READ;
                    s_d.mreq   = 1'b1;
                    s_d.mwe    = 1'b0;
                    s_d.maddr  = step_addr_i;                                  // RULE_15
                end
            end
            SAC_S_READ: begin
                // Entry read from memory each walk, so no stale cached rights here
                if (mem_ack_i) begin                                           // RULE_07
                    s_d.mreq = 1'b0;
                    s_d.st   = SAC_S_EVAL;
                    if (checked) begin
                        if (entry_bad) begin
                            s_d.st     = SAC_S_FINISH;                         // RULE_06 RULE_23
                            s_d.done   = 1'b1;
                            s_d.fault  = 1'b1;
                            s_d.reason = SAC_F_TRANS;
                        end else begin
                            s_d.acc_r = s_q.acc_r && mem_rdata_i[SAC_E_R];
                            s_d.acc_w = s_q.acc_w && mem_rdata_i[SAC_E_W];
                            s_d.acc_x = s_q.acc_x && mem_rdata_i[SAC_E_X];
                            // Flags go out before the rights verdict
                            if (set_mask != 64'h0) begin                       // RULE_11
                                s_d.st     = SAC_S_UPD;
                                s_d.mreq   = 1'b1;
                                s_d.mwe    = 1'b1;
                                s_d.mwdata = set_mask;                         // RULE_12
                            end
                        end
                    end
                end
            end
            SAC_S_UPD: begin
                if (mem_ack_i) begin
                    s_d.mreq   = 1'b0;
                    s_d.mwe    = 1'b0;
                    s_d.mwdata = 64'h0;
                    s_d.st     = SAC_S_EVAL;
                end
            end
            SAC_S_EVAL: begin
                if (!s_q.last) begin
                    s_d.st     = SAC_S_STEP;
                    s_d.sready = 1'b1;
                end else if (checked && !rights_ok) begin
                    s_d.st     = SAC_S_FINISH;                                 // RULE_16 RULE_24
                    s_d.done   = 1'b1;
                    s_d.fault  = 1'b1;
                    s_d.reason = SAC_F_PERM;
                end else if (s_q.cls == SAC_C_FINAL) begin
                    s_d.st    = SAC_S_FINISH;
                    s_d.done  = 1'b1;
                    s_d.grant = 1'b1;
                    s_d.oaddr = s_q.soaddr;
                end else begin
                    // Next stage-two walk starts with fresh rights
                    s_d.st     = SAC_S_STEP;
                    s_d.sready = 1'b1;
                    s_d.acc_r  = 1'b1;
                    s_d.acc_w  = 1'b1;
                    s_d.acc_x  = 1'b1;
                end
            end
            SAC_S_FINISH: begin
                if (s_q.fault) begin
                    s_d.fcnt = s_q.fcnt + 16'h0001;
                end
                s_d.st     = SAC_S_IDLE;
                s_d.rready = 1'b1;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q          <= '0;
            s_q.st       <= SAC_S_IDLE;
            s_q.ttype    <= SAC_RST_TYPE;
            s_q.host_address_width      <= SAC_RST_HAW;
            s_q.dpasid   <= SAC_RST_PASID;
            s_q.rready   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o       = s_q.rdat;
    assign wb_ack_o       = s_q.ack;
    assign wb_err_o       = s_q.err;
    assign req_ready_o    = s_q.rready;
    assign step_ready_o   = s_q.sready;
    assign mem_req_o      = s_q.mreq;
    assign mem_we_o       = s_q.mwe;
    assign mem_addr_o     = s_q.maddr;
    assign mem_wdata_o    = s_q.mwdata;
    assign done_o         = s_q.done;
    assign grant_o        = s_q.grant;
    assign fault_o        = s_q.fault;
    assign fault_reason_o = s_q.reason;
    assign out_addr_o     = s_q.oaddr;
    assign out_pasid_o    = s_q.opasid;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_pt_accept;
        accept && pt_mode;
    endsequence

    sequence seq_bad_entry;
        s_q.st == SAC_S_READ && mem_ack_i && checked && entry_bad;
    endsequence

    sequence seq_fresh_use;
        s_q.st == SAC_S_READ && mem_ack_i && checked && !entry_bad && track_eff &&
        !mem_rdata_i[SAC_E_ACC];
    endsequence

    chk_pt_addr_back: assert property (seq_pt_accept and !above_haw |=> done_o && grant_o && // RULE_21
        out_addr_o == $past(req_addr_i))
        else $error("pass-through address not returned");
    chk_pt_haw_fault: assert property (seq_pt_accept and above_haw |=> done_o && fault_o && // RULE_22
        fault_reason_o == SAC_F_HAW)
        else $error("pass-through width violation not faulted");
    chk_pt_no_walk: assert property (seq_pt_accept |=> !mem_req_o [*2]) // RULE_21
        else $error("pass-through touched walk memory");
    chk_bad_entry_fault: assert property (seq_bad_entry |=> done_o && fault_o && // RULE_23
        fault_reason_o == SAC_F_TRANS ##1 !mem_req_o)
        else $error("unusable entry did not fault");
    chk_accessed_set: assert property (seq_fresh_use |=> s_q.st == SAC_S_UPD && mem_we_o && // RULE_09
        mem_wdata_o[SAC_E_ACC] && mem_addr_o == $past(s_q.maddr))
        else $error("accessed flag not set on use");
    chk_flags_only_set: assert property (mem_req_o && mem_we_o |-> // RULE_12
        (mem_wdata_o & ~(64'h1 << SAC_E_ACC | 64'h1 << SAC_E_DIRT)) == 64'h0 && mem_wdata_o != 64'h0)
        else $error("flag write carries other bits");
    chk_fault_no_grant: assert property (done_o && fault_o |-> !grant_o ##1 req_ready_o) // RULE_24
        else $error("faulted request was granted");
    chk_write_rights: assert property (done_o && grant_o && !pt_mode && // RULE_04
        s_q.kind == SAC_K_WRITE |-> s_q.acc_w)
        else $error("write granted without write right");
    chk_atomic_rights: assert property (done_o && grant_o && !pt_mode && // RULE_05
        s_q.kind == SAC_K_ATOMIC |-> s_q.acc_r && s_q.acc_w)
        else $error("atomic granted without read and write");
    chk_fetch_rights: assert property (done_o && grant_o && !pt_mode && s_q.fetch && // RULE_03
        s_q.exec_en |-> s_q.acc_r && s_q.acc_x)
        else $error("fetch granted without execute right");
    chk_default_pasid: assert property (accept && !req_has_pasid_i |=> // RULE_14
        out_pasid_o == $past(s_q.dpasid))
        else $error("default requester PASID not used");
    chk_bus_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus answer held too long");

endmodule : sac_checker

// ### sac_pkg.sv
// Purpose: Shared constants and types for the stage-two access rights checker
// Assumes: Wishbone register slave with 32-bit data and byte addresses
// Notes:   Entry bit positions follow the second-stage paging entry layout
package sac_pkg;

    // Register byte offsets
    localparam logic [7:0] SAC_OFS_CTRL   = 8'h00;
    localparam logic [7:0] SAC_OFS_HAW    = 8'h04;
    localparam logic [7:0] SAC_OFS_PASID  = 8'h08;
    localparam logic [7:0] SAC_OFS_STATUS = 8'h0C;
    localparam logic [7:0] SAC_OFS_FADDR  = 8'h10;

    // Control register field positions
    localparam int SAC_CTRL_EXEC_BIT  = 0;
    localparam int SAC_CTRL_TRACK_BIT = 1;
    localparam int SAC_CTRL_TYPE_LSB  = 2;

    // Reset values
    localparam logic [2:0]  SAC_RST_TYPE  = 3'h2;
    localparam logic [5:0]  SAC_RST_HAW   = 6'h27;
    localparam logic [19:0] SAC_RST_PASID = 20'h00000;

    // Second-stage entry bit positions
    localparam int SAC_E_R    = 0;
    localparam int SAC_E_W    = 1;
    localparam int SAC_E_X    = 2;
    localparam int SAC_E_PS   = 7;
    localparam int SAC_E_ACC  = 8;
    localparam int SAC_E_DIRT = 9;
    localparam int SAC_E_TOP  = 51;

    // Per-PASID translation type encodings
    localparam logic [2:0] SAC_TT_FIRST = 3'h1;
    localparam logic [2:0] SAC_TT_SECOND = 3'h2;
    localparam logic [2:0] SAC_TT_NESTED = 3'h3;
    localparam logic [2:0] SAC_TT_PASS  = 3'h4;

    // Request kinds
    localparam logic [1:0] SAC_K_READ   = 2'h0;
    localparam logic [1:0] SAC_K_WRITE  = 2'h1;
    localparam logic [1:0] SAC_K_ATOMIC = 2'h2;

    // Walk step classes
    localparam logic [1:0] SAC_C_CTX   = 2'h0;
    localparam logic [1:0] SAC_C_FS    = 2'h1;
    localparam logic [1:0] SAC_C_FINAL = 2'h2;

    // Fault reasons
    localparam logic [2:0] SAC_F_NONE  = 3'h0;
    localparam logic [2:0] SAC_F_TRANS = 3'h1;
    localparam logic [2:0] SAC_F_PERM  = 3'h2;
    localparam logic [2:0] SAC_F_HAW   = 3'h3;
    localparam logic [2:0] SAC_F_CFG   = 3'h4;

    typedef enum logic [2:0] {
        SAC_S_IDLE,
        SAC_S_STEP,
        SAC_S_READ,
        SAC_S_UPD,
        SAC_S_EVAL,
        SAC_S_FINISH
    } sac_state_t;

endpackage : sac_pkg

// ### sac_walk_mem.sv
// Purpose: Page-walk memory behind the checker's memory port
// Assumes: A write is an atomic OR of the data into the entry
// Notes:   Answers alternate between prompt and two cycles late
`timescale 1ns/1ps
module sac_walk_mem (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        mem_req_i,
    input  wire logic        mem_we_i,
    input  wire logic [63:0] mem_addr_i,
    input  wire logic [63:0] mem_wdata_i,
    output logic             mem_ack_o,
    output logic      [63:0] mem_rdata_o
);
    logic [63:0] mem [16];
    logic [1:0]  wait_q;
    logic        slow_q;
    // Serve one access; read data is valid only in its ack cycle, and the read bus inverts in every cycle except a read's ack cycle
    always @(posedge clk_i) begin
        mem_ack_o <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o;
        if (rst_i) begin
            wait_q <= 2'h0;
            slow_q <= 1'b0;
            mem_rdata_o <= 64'h0;
        end else if (mem_req_i && !mem_ack_o) begin
            if (wait_q < {slow_q, 1'b0}) begin
                wait_q <= wait_q + 2'h1;
            end else begin
                mem_ack_o <= 1'b1;
                wait_q <= 2'h0;
                slow_q <= ~slow_q;
                if (mem_we_i) mem[mem_addr_i[6:3]] <= mem[mem_addr_i[6:3]] | mem_wdata_i;
                else mem_rdata_o <= mem[mem_addr_i[6:3]];
            end
        end
    end
endmodule : sac_walk_mem

// ### testbench.sv
// Purpose: Self-checking bench for the stage-two access rights checker
// Assumes: Bench plays the walker; sac_walk_mem plays memory
// Notes:   Entries sit at host addresses 0x00 to 0x18
`timescale 1ns/1ps
module testbench
    import sac_pkg::*;
;
    logic        clk_i, rst_i, cs, we, ack, err, rv, rr, sv, sr, last, fsupd, fetch, hasp;
    logic        mreq, mwe, mack, done, grant, fault;
    logic [1:0]  kind, cls;
    logic [2:0]  reason;
    logic [7:0]  adr;
    logic [19:0] opas;
    logic [31:0] wdat, rdat, rd;
    logic [63:0] raddr, saddr, maddr, mwd, mrd, oaddr;
    logic [7:0]  cases [9] = '{8'h03, 8'h04, 8'h23, 8'h32, 8'h3B, 8'h45, 8'h42, 8'h87, 8'h84};
    int          errors, tests_run;
    sac_checker i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cs), .wb_stb_i(cs), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .req_valid_i(rv), .req_ready_o(rr), .req_addr_i(raddr), .req_kind_i(kind),
        .fetch_request_flag_i(fetch), .req_has_pasid_i(hasp), .req_pasid_i(20'h00011),
        .step_valid_i(sv), .step_ready_o(sr), .step_addr_i(saddr), .step_class_i(cls), .step_last_i(last),
        .step_fs_update_i(fsupd), .step_out_addr_i(64'h1234), .mem_req_o(mreq), .mem_we_o(mwe),
        .mem_addr_o(maddr), .mem_wdata_o(mwd), .mem_ack_i(mack), .mem_rdata_i(mrd), .done_o(done),
        .grant_o(grant), .fault_o(fault), .fault_reason_o(reason), .out_addr_o(oaddr), .out_pasid_o(opas));
    sac_walk_mem i_mem (.clk_i(clk_i), .rst_i(rst_i), .mem_req_i(mreq), .mem_we_i(mwe),
        .mem_addr_i(maddr), .mem_wdata_i(mwd), .mem_ack_o(mack), .mem_rdata_o(mrd));
    // Clock at 250 MHz
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        cs <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (!(ack || err));
        rd = rdat;
        chk("bus error", 64'(e), 64'(err));
        cs <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic req(input logic [1:0] k, input logic f, input logic [63:0] a, input logic p);
        rv <= 1'b1;
        kind <= k;
        fetch <= f;
        raddr <= a;
        hasp <= p;
        do @(posedge clk_i); while (!rr);
        rv <= 1'b0;
    endtask : req
    task automatic step(input logic [63:0] a, input logic [1:0] c, input logic l, input logic u);
        sv <= 1'b1;
        saddr <= a;
        cls <= c;
        last <= l;
        fsupd <= u;
        do @(posedge clk_i); while (!sr);
        sv <= 1'b0;
        @(posedge clk_i);
    endtask : step
    // Two-entry final walk: entry 0 then leaf 1
    task automatic walk2;
        step(64'h0, SAC_C_FINAL, 1'b0, 1'b0);
        step(64'h8, SAC_C_FINAL, 1'b1, 1'b0);
    endtask : walk2
    task automatic fin(input logic g, input logic [2:0] r);
        do @(posedge clk_i); while (!done);
        chk("grant", 64'(g), 64'(grant));
        chk("fault", 64'(!g), 64'(fault));
        chk("reason", 64'(r), 64'(reason));
    endtask : fin
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        print_verdict();
    end
    // Main sequence
    initial begin
        errors = 0;
        tests_run = 0;
        rst_i = 1'b1;
        {cs, we, rv, fetch, hasp, sv, last, fsupd} = '0;
        {adr, wdat, kind, raddr, saddr, cls} = '0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, SAC_OFS_CTRL, 32'h0, 1'b0);
        chk("ctrl reset", 64'h08, 64'(rd));
        wb(1'b0, SAC_OFS_HAW, 32'h0, 1'b0);
        chk("haw reset", 64'h27, 64'(rd));
        wb(1'b0, 8'h20, 32'h0, 1'b1);
        $display("test registers done");
        wb(1'b1, SAC_OFS_CTRL, 32'h10, 1'b0);
        req(SAC_K_WRITE, 1'b0, 64'h0000_0040_0000_1000, 1'b1);
        fin(1'b1, SAC_F_NONE);
        chk("out addr", 64'h0000_0040_0000_1000, oaddr);
        req(SAC_K_READ, 1'b0, 64'h0000_0080_0000_1000, 1'b1);
        fin(1'b0, SAC_F_HAW);
        $display("test pass-through done");
        i_mem.mem[0] = 64'h7;
        foreach (cases[i]) begin
            wb(1'b1, SAC_OFS_CTRL, 32'h08 | 32'(cases[i][4]), 1'b0);
            i_mem.mem[1] = 64'(cases[i][3:1]);
            req(cases[i][7:6], cases[i][5], 64'h1000, 1'b1);
            walk2();
            fin(cases[i][0], cases[i][0] ? SAC_F_NONE : SAC_F_PERM);
        end
        for (int i = 0; i < 2; i++) begin
            i_mem.mem[1] = i ? 64'h0008_0000_0000_0003 : 64'h0;
            req(SAC_K_READ, 1'b0, 64'h1000, 1'b1);
            walk2();
            fin(1'b0, SAC_F_TRANS);
        end
        $display("test rights done");
        wb(1'b1, SAC_OFS_CTRL, 32'h0A, 1'b0);
        i_mem.mem[0] = 64'h3;
        i_mem.mem[1] = 64'h3;
        req(SAC_K_WRITE, 1'b0, 64'h1000, 1'b1);
        walk2();
        fin(1'b1, SAC_F_NONE);
        chk("accessed", 64'h103, i_mem.mem[0]);
        chk("dirty", 64'h303, i_mem.mem[1]);
        req(SAC_K_READ, 1'b0, 64'h1000, 1'b1);
        walk2();
        fin(1'b1, SAC_F_NONE);
        chk("sticky", 64'h303, i_mem.mem[1]);
        $display("test flags done");
        wb(1'b1, SAC_OFS_PASID, 32'h000ABCDE, 1'b0);
        wb(1'b1, SAC_OFS_CTRL, 32'h0C, 1'b0);
        i_mem.mem[1] = 64'h1;
        i_mem.mem[2] = 64'h0;
        i_mem.mem[3] = 64'h1;
        req(SAC_K_READ, 1'b0, 64'h1000, 1'b0);
        step(64'h10, SAC_C_CTX, 1'b0, 1'b0);
        step(64'h18, SAC_C_FS, 1'b1, 1'b0);
        step(64'h8, SAC_C_FINAL, 1'b1, 1'b0);
        fin(1'b1, SAC_F_NONE);
        chk("addr", 64'h1234, oaddr);
        chk("pasid", 64'h000ABCDE, 64'(opas));
        req(SAC_K_READ, 1'b0, 64'h1000, 1'b1);
        step(64'h18, SAC_C_FS, 1'b1, 1'b1);
        fin(1'b0, SAC_F_PERM);
        wb(1'b1, SAC_OFS_CTRL, 32'h0E, 1'b0);
        req(SAC_K_READ, 1'b0, 64'h1000, 1'b1);
        step(64'h18, SAC_C_FS, 1'b1, 1'b0);
        fin(1'b0, SAC_F_PERM);
        $display("test nested done");
        print_verdict();
    end
endmodule : testbench
